/* spi_master_dma_config.sv */
// spi master: register file, byte sequencer with dma port, serial engine on the link clock
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_unit_cfg_map.svh"

module spi_master_dma_config (
   input  wire logic          clk_sys_i,
   input  wire logic          rst_n_i,
   input  wire logic          clk_link_i,
   input  wire logic [11:0]   reg_addr_i,
   input  wire spi_master_unit_pkg::word_t reg_wdata_i,
   input  wire logic          reg_we_i,
   input  wire logic          reg_re_i,
   output spi_master_unit_pkg::word_t    reg_rdata_o,
   input  wire logic          start_i,
   output logic               busy_o,
   output logic               end_o,
   output logic               dma_rd_req_o,
   output spi_master_unit_pkg::word_t    dma_rd_addr_o,
   input  wire logic          dma_rd_ack_i,
   input  wire spi_master_unit_pkg::byte_t dma_rd_data_i,
   output logic               dma_wr_req_o,
   output spi_master_unit_pkg::word_t    dma_wr_addr_o,
   output spi_master_unit_pkg::byte_t    dma_wr_data_o,
   input  wire logic          dma_wr_ack_i,
   output logic               sck_o,
   output logic               mosi_o,
   input  wire logic          miso_i
);
   import spi_master_unit_pkg::*;

   sys_state_t  s_q;
   sys_state_t  s_d;
   link_state_t lk_q;
   link_state_t lk_d;

   // rate code to link-clock half periods; unknown codes fall back to 250 kbps
   function automatic logic [8:0] half_of(input word_t code);
      case (code)
         `RATE_125K: half_of = `HALF_125K;
         `RATE_250K: half_of = `HALF_250K;
         `RATE_500K: half_of = `HALF_500K;
         `RATE_1MEG: half_of = `HALF_1MEG;
         `RATE_2MEG: half_of = `HALF_2MEG;
         `RATE_4MEG: half_of = `HALF_4MEG;
         `RATE_8MEG: half_of = `HALF_8MEG;
         default:    half_of = `HALF_250K;
      endcase
   endfunction

   // ---------------- system clock domain ----------------
   always_comb begin
      logic adv;
      adv = 1'b0;
      s_d = s_q;
      s_d.end_p = 1'b0;
      s_d.rdata = `RST_WORD_ZERO;
      s_d.ack_s1 = lk_q.ack_tgl;
      s_d.ack_s2 = s_q.ack_s1;
      if (reg_we_i) begin
         case (reg_addr_i)
            `OFS_BIT_RATE_SELECT: s_d.rate = reg_wdata_i;
            `OFS_RX_BUFFER_POINTER: begin
               s_d.rx_ptr = reg_wdata_i;
               s_d.rx_base = reg_wdata_i;
            end
            `OFS_RX_BYTE_LIMIT: s_d.rx_lim = reg_wdata_i[14:0];
            `OFS_RX_LIST_TYPE: s_d.rx_list = reg_wdata_i[1:0];
            `OFS_TX_BUFFER_POINTER: begin
               s_d.tx_ptr = reg_wdata_i;
               s_d.tx_base = reg_wdata_i;
            end
            `OFS_TX_BYTE_COUNT_LIMIT: s_d.tx_lim = reg_wdata_i[14:0];
            `OFS_TX_LIST_TYPE: s_d.tx_list = reg_wdata_i[1:0];
            `OFS_SERIAL_FORMAT_CONFIG: s_d.cfg = reg_wdata_i[2:0];
            `OFS_OVERREAD_FILLER: s_d.overread_filler = reg_wdata_i[7:0];
            default: s_d.rate = s_q.rate;
         endcase
      end
      if (reg_re_i) begin
         case (reg_addr_i)
            `OFS_BIT_RATE_SELECT:      s_d.rdata = s_q.rate;
            `OFS_RX_BUFFER_POINTER:    s_d.rdata = s_q.rx_ptr;
            `OFS_RX_BYTE_LIMIT:        s_d.rdata = {17'h00000, s_q.rx_lim};
            `OFS_RX_BYTE_COUNT:        s_d.rdata = {17'h00000, s_q.rx_amt};
            `OFS_RX_LIST_TYPE:         s_d.rdata = {30'h00000000, s_q.rx_list};
            `OFS_TX_BUFFER_POINTER:    s_d.rdata = s_q.tx_ptr;
            `OFS_TX_BYTE_COUNT_LIMIT:  s_d.rdata = {17'h00000, s_q.tx_lim};
            `OFS_TX_BYTE_COUNT:        s_d.rdata = {17'h00000, s_q.tx_amt};
            `OFS_TX_LIST_TYPE:         s_d.rdata = {30'h00000000, s_q.tx_list};
            `OFS_SERIAL_FORMAT_CONFIG: s_d.rdata = {29'h00000000, s_q.cfg};
            `OFS_OVERREAD_FILLER:      s_d.rdata = {24'h000000, s_q.overread_filler};
            default:                   s_d.rdata = `RST_WORD_ZERO;
         endcase
      end
      case (s_q.st)
         S_IDLE: begin
            if (start_i) begin
               // length is the larger of both
               s_d.total = (s_q.rx_lim > s_q.tx_lim) ? s_q.rx_lim : s_q.tx_lim;
               s_d.idx = 15'h0000;
               s_d.rxc = 15'h0000;
               s_d.txc = 15'h0000;
               s_d.st = (s_d.total == 15'h0000) ? S_DONE : S_FETCH;
            end
         end
         S_FETCH: begin
            // format is frozen per byte so the link never sees a half-written word
            s_d.req.half = half_of(s_q.rate);
            s_d.req.order = s_q.cfg[`CFG_ORDER_BIT];
            s_d.req.clock_phase = s_q.cfg[`CFG_PHASE_BIT];
            s_d.req.clock_polarity = s_q.cfg[`CFG_POLARITY_BIT];
            if (s_q.idx < s_q.tx_lim) begin
               if (!s_q.rd_req) begin
                  s_d.rd_req = 1'b1;
                  s_d.rd_addr = s_q.tx_base + {17'h00000, s_q.idx};
               end else if (dma_rd_ack_i) begin
                  s_d.rd_req = 1'b0;
                  s_d.req.tx = dma_rd_data_i;
                  s_d.txc = s_q.txc + 15'h0001;
                  s_d.req_tgl = ~s_q.req_tgl;
                  s_d.st = S_XFER;
               end
            end else begin
               s_d.req.tx = s_q.overread_filler;
               s_d.req_tgl = ~s_q.req_tgl;
               s_d.st = S_XFER;
            end
         end
         S_XFER: begin
            if (s_q.ack_s2 != s_q.ack_seen) begin
               s_d.ack_seen = s_q.ack_s2;
               s_d.wr_data = lk_q.rx;
               if (s_q.idx < s_q.rx_lim) begin
                  s_d.wr_req = 1'b1;
                  s_d.wr_addr = s_q.rx_base + {17'h00000, s_q.idx};
                  s_d.st = S_STORE;
               end else begin
                  adv = 1'b1;
               end
            end
         end
         S_STORE: begin
            if (dma_wr_ack_i) begin
               s_d.wr_req = 1'b0;
               s_d.rxc = s_q.rxc + 15'h0001;
               adv = 1'b1;
            end
         end
         S_DONE: begin
            s_d.rx_amt = s_q.rxc;
            s_d.tx_amt = s_q.txc;
            s_d.end_p = 1'b1;
            s_d.st = S_IDLE;
            if (s_q.rx_list == `LIST_CONSECUTIVE) begin
               s_d.rx_base = s_q.rx_base + {17'h00000, s_q.rx_lim};
            end
            if (s_q.tx_list == `LIST_CONSECUTIVE) begin
               s_d.tx_base = s_q.tx_base + {17'h00000, s_q.tx_lim};
            end
         end
         default: s_d.st = S_IDLE;
      endcase
      if (adv) begin
         if (s_q.idx == s_q.total - 15'h0001) begin
            s_d.st = S_DONE;
         end else begin
            s_d.idx = s_q.idx + 15'h0001;
            s_d.st = S_FETCH;
         end
      end
      if (!rst_n_i) begin
         s_d = '0;
         s_d.rate = `RST_BIT_RATE_SELECT;
         s_d.st = S_IDLE;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      s_q <= s_d;
   end

   assign reg_rdata_o   = s_q.rdata;
   assign busy_o        = (s_q.st != S_IDLE);
   assign end_o         = s_q.end_p;
   assign dma_rd_req_o  = s_q.rd_req;
   assign dma_rd_addr_o = s_q.rd_addr;
   assign dma_wr_req_o  = s_q.wr_req;
   assign dma_wr_addr_o = s_q.wr_addr;
   assign dma_wr_data_o = s_q.wr_data;

   // ---------------- link clock domain ----------------
   // miso passes two flops, so at the fastest rate it is sampled two link cycles late
   always_comb begin
      logic sample;
      byte_t nsh;
      sample = 1'b0;
      nsh = lk_q.sh;
      lk_d = lk_q;
      lk_d.rst_s1 = rst_n_i;
      lk_d.rst_s2 = lk_q.rst_s1;
      lk_d.miso_s1 = miso_i;
      lk_d.miso_s2 = lk_q.miso_s1;
      lk_d.clock_polarity_s1 = s_q.cfg[`CFG_POLARITY_BIT];
      lk_d.clock_polarity_s2 = lk_q.clock_polarity_s1;
      lk_d.req_s1 = s_q.req_tgl;
      lk_d.req_s2 = lk_q.req_s1;
      case (lk_q.st)
         L_IDLE: begin
            lk_d.sck = lk_q.clock_polarity_s2;
            if (lk_q.req_s2 != lk_q.req_seen) begin
               lk_d.req_seen = lk_q.req_s2;
               lk_d.cur = s_q.req;
               lk_d.sh = s_q.req.tx;
               lk_d.mosi = s_q.req.order ? s_q.req.tx[0] : s_q.req.tx[7];
               lk_d.sck = s_q.req.clock_polarity;
               lk_d.div = 9'h000;
               lk_d.edge_n = 4'h0;
               lk_d.st = L_RUN;
            end
         end
         L_RUN: begin
            if (lk_q.div >= lk_q.cur.half - 9'h001) begin
               lk_d.div = 9'h000;
               lk_d.sck = ~lk_q.sck;
               sample = (~lk_q.edge_n[0]) ^ lk_q.cur.clock_phase;
               if (sample) begin
                  lk_d.rx = lk_q.cur.order ? {lk_q.miso_s2, lk_q.rx[7:1]}
                                           : {lk_q.rx[6:0], lk_q.miso_s2};
               end else if (lk_q.edge_n != 4'h0) begin
                  nsh = lk_q.cur.order ? {1'b0, lk_q.sh[7:1]} : {lk_q.sh[6:0], 1'b0};
                  lk_d.sh = nsh;
                  lk_d.mosi = lk_q.cur.order ? nsh[0] : nsh[7];
               end
               if (lk_q.edge_n == `LAST_EDGE) begin
                  lk_d.ack_tgl = ~lk_q.ack_tgl;
                  lk_d.st = L_IDLE;
               end else begin
                  lk_d.edge_n = lk_q.edge_n + 4'h1;
               end
            end else begin
               lk_d.div = lk_q.div + 9'h001;
            end
         end
         default: lk_d.st = L_IDLE;
      endcase
      if (!lk_q.rst_s2) begin
         lk_d = '0;
         lk_d.rst_s1 = rst_n_i;
         lk_d.rst_s2 = lk_q.rst_s1;
         lk_d.st = L_IDLE;
      end
   end

   always_ff @(posedge clk_link_i) begin
      lk_q <= lk_d;
   end

   assign sck_o  = lk_q.sck;
   assign mosi_o = lk_q.mosi;

   // ---------------- checks ----------------
   rate_reset_a: assert property (@(posedge clk_sys_i)
      $rose(rst_n_i) |-> s_q.rate == `RST_BIT_RATE_SELECT)
      else $error("rate select not at reset value");
   rx_addr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(dma_wr_req_o) |-> dma_wr_addr_o == s_q.rx_base + {17'h00000, s_q.idx})
      else $error("rx write address wrong");
   rx_limit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(dma_wr_req_o) |-> $past(s_q.idx) < $past(s_q.rx_lim))
      else $error("rx write beyond limit");
   amount_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_re_i && reg_addr_i == `OFS_RX_BYTE_COUNT
      |=> reg_rdata_o == {17'h00000, $past(s_q.rx_amt)})
      else $error("rx amount readback wrong");
   tx_addr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(dma_rd_req_o) |-> dma_rd_addr_o == s_q.tx_base + {17'h00000, s_q.idx})
      else $error("tx fetch address wrong");
   end_counts_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      end_o |-> s_q.rx_amt <= s_q.rx_lim && s_q.tx_amt <= s_q.tx_lim)
      else $error("transferred counts exceed limits");
   list_advance_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      end_o && $past(s_q.rx_list) == `LIST_CONSECUTIVE
      |-> s_q.rx_base == $past(s_q.rx_base) + {17'h00000, $past(s_q.rx_lim)})
      else $error("rx buffer did not advance");
   filler_sent_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_q.st == S_FETCH && s_q.idx >= s_q.tx_lim |=> s_q.req.tx == $past(s_q.overread_filler))
      else $error("filler byte not sent");
   first_bit_a: assert property (@(posedge clk_link_i) disable iff (!lk_q.rst_s2)
      lk_q.st == L_IDLE && lk_q.req_s2 != lk_q.req_seen
      |=> mosi_o == (lk_q.cur.order ? lk_q.cur.tx[0] : lk_q.cur.tx[7]))
      else $error("first data bit wrong");
   sck_idle_a: assert property (@(posedge clk_link_i) disable iff (!lk_q.rst_s2)
      (lk_q.st == L_IDLE)[*2] |-> sck_o == $past(lk_q.clock_polarity_s2))
      else $error("clock idle level wrong");
   edge_count_a: assert property (@(posedge clk_link_i) disable iff (!lk_q.rst_s2)
      $changed(lk_q.ack_tgl) |-> $past(lk_q.edge_n) == `LAST_EDGE && sck_o == lk_q.cur.clock_polarity)
      else $error("byte ended off its last edge");

   done_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) end_o);
   filler_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_q.st == S_FETCH && s_q.idx >= s_q.tx_lim);
   lsb_phase_c: cover property (@(posedge clk_link_i) disable iff (!lk_q.rst_s2)
      lk_q.st == L_RUN && lk_q.cur.order && lk_q.cur.clock_phase);
   polarity_c: cover property (@(posedge clk_link_i) disable iff (!lk_q.rst_s2)
      lk_q.st == L_RUN && lk_q.cur.clock_polarity);
endmodule // spi_master_dma_config

`default_nettype wire

/* spi_master_unit_cfg_map.svh */
// register offsets, reset values, field positions and timing counts of the spi master
`ifndef SPI_MASTER_UNIT_CFG_MAP_SVH
`define SPI_MASTER_UNIT_CFG_MAP_SVH

`define OFS_BIT_RATE_SELECT      12'h524
`define OFS_RX_BUFFER_POINTER    12'h534
`define OFS_RX_BYTE_LIMIT        12'h538
`define OFS_RX_BYTE_COUNT        12'h53C
`define OFS_RX_LIST_TYPE         12'h540
`define OFS_TX_BUFFER_POINTER    12'h544
`define OFS_TX_BYTE_COUNT_LIMIT  12'h548
`define OFS_TX_BYTE_COUNT        12'h54C
`define OFS_TX_LIST_TYPE         12'h550
`define OFS_SERIAL_FORMAT_CONFIG 12'h554
`define OFS_OVERREAD_FILLER      12'h5C0

`define RST_BIT_RATE_SELECT      32'h04000000
`define RST_WORD_ZERO            32'h00000000

`define RATE_125K                32'h02000000
`define RATE_250K                32'h04000000
`define RATE_500K                32'h08000000
`define RATE_1MEG                32'h10000000
`define RATE_2MEG                32'h20000000
`define RATE_4MEG                32'h40000000
`define RATE_8MEG                32'h80000000

`define CFG_ORDER_BIT            0
`define CFG_PHASE_BIT            1
`define CFG_POLARITY_BIT         2
`define LIST_CONSECUTIVE         2'h1

`define LINK_PERIOD_PS           64'd15000
`define HALF_CYC(hz)             9'((64'd1000000000000 / (64'd2 * (hz))) / `LINK_PERIOD_PS)
`define HALF_125K                `HALF_CYC(64'd125000)
`define HALF_250K                `HALF_CYC(64'd250000)
`define HALF_500K                `HALF_CYC(64'd500000)
`define HALF_1MEG                `HALF_CYC(64'd1000000)
`define HALF_2MEG                `HALF_CYC(64'd2000000)
`define HALF_4MEG                `HALF_CYC(64'd4000000)
`define HALF_8MEG                `HALF_CYC(64'd8000000)
`define LAST_EDGE                4'hF

`endif

/* spi_master_unit_pkg.sv */
// types shared by the spi master: states, crossing word and state records
package spi_master_unit_pkg;
   typedef logic [7:0]  byte_t;
   typedef logic [31:0] word_t;
   typedef logic [14:0] cnt_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_FETCH = 3'h1,
      S_XFER  = 3'h3,
      S_STORE = 3'h2,
      S_DONE  = 3'h6
   } sys_fsm_t;

   typedef enum logic {
      L_IDLE = 1'b0,
      L_RUN  = 1'b1
   } link_fsm_t;

   typedef struct packed {
      byte_t      tx;
      logic [8:0] half;
      logic       clock_phase;
      logic       order;
      logic       clock_polarity;
   } link_req_t;

   typedef struct packed {
      word_t     rate;
      word_t     rx_ptr;
      cnt_t      rx_lim;
      cnt_t      rx_amt;
      logic [1:0] rx_list;
      word_t     tx_ptr;
      cnt_t      tx_lim;
      cnt_t      tx_amt;
      logic [1:0] tx_list;
      logic [2:0] cfg;
      byte_t     overread_filler;
      word_t     rx_base;
      word_t     tx_base;
      sys_fsm_t  st;
      cnt_t      idx;
      cnt_t      total;
      cnt_t      rxc;
      cnt_t      txc;
      link_req_t req;
      logic      req_tgl;
      logic      ack_s1;
      logic      ack_s2;
      logic      ack_seen;
      word_t     rdata;
      logic      end_p;
      logic      rd_req;
      word_t     rd_addr;
      logic      wr_req;
      word_t     wr_addr;
      byte_t     wr_data;
   } sys_state_t;

   typedef struct packed {
      logic      rst_s1;
      logic      rst_s2;
      logic      miso_s1;
      logic      miso_s2;
      logic      clock_polarity_s1;
      logic      clock_polarity_s2;
      logic      req_s1;
      logic      req_s2;
      logic      req_seen;
      logic      ack_tgl;
      link_fsm_t st;
      link_req_t cur;
      logic [8:0] div;
      logic [3:0] edge_n;
      byte_t     sh;
      byte_t     rx;
      logic      sck;
      logic      mosi;
   } link_state_t;
endpackage

/* spi_slave_model.sv */
// behavioural spi slave that answers the master on the serial lines
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model (
   input  wire logic sck_i,
   input  wire logic mosi_i,
   input  wire logic clock_polarity_i,
   input  wire logic clock_phase_i,
   input  wire logic order_i,
   output logic      miso_o
);
   import spi_master_unit_pkg::*;
   int    frame_n = 0;
   int    edge_n  = 0;
   int    pos     = 0;
   byte_t sh_in   = 8'h00;
   byte_t got_q[$];
   logic  lead;

   function automatic byte_t pat(input int f);
      return byte_t'(f * 77) ^ 8'hC3;
   endfunction

   task automatic drive();
      int    idx;
      byte_t cur;
      cur = pat(frame_n);
      idx = clock_phase_i ? pos - 1 : pos;
      // outside a bit slot the line toggles so a stale value never passes
      if (idx < 0 || idx > 7) miso_o = ~miso_o;
      else miso_o = order_i ? cur[idx] : cur[7 - idx];
   endtask

   initial miso_o = 1'b0;
   always @(clock_phase_i, order_i) if (edge_n == 0) drive();

   always @(sck_i) begin
      lead = (sck_i !== clock_polarity_i);
      // no chip select: an idle level change between frames is not an edge
      if (edge_n != 0 || lead) begin
         if (lead ^ clock_phase_i) sh_in = order_i ? {mosi_i, sh_in[7:1]} : {sh_in[6:0], mosi_i};
         else pos = pos + 1;
         edge_n = edge_n + 1;
         if (edge_n == 16) begin
            got_q.push_back(sh_in);
            frame_n = frame_n + 1;
            edge_n  = 0;
            pos     = 0;
         end
         drive();
      end
   end
endmodule // spi_slave_model

`default_nettype wire

/* spi_master_dma_config_bench.sv */
// self-checking bench for the spi master: registers, dma port and serial link
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_unit_cfg_map.svh"

module spi_master_dma_config_bench;
   import spi_master_unit_pkg::*;
   localparam logic [11:0] ofs_tab [11] = '{`OFS_BIT_RATE_SELECT, `OFS_RX_BUFFER_POINTER,
      `OFS_RX_BYTE_LIMIT, `OFS_RX_BYTE_COUNT, `OFS_RX_LIST_TYPE, `OFS_TX_BUFFER_POINTER,
      `OFS_TX_BYTE_COUNT_LIMIT, `OFS_TX_BYTE_COUNT, `OFS_TX_LIST_TYPE,
      `OFS_SERIAL_FORMAT_CONFIG, `OFS_OVERREAD_FILLER};
   localparam word_t msk_tab [11] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00007FFF, 32'h0,
      32'h3, 32'hFFFFFFFF, 32'h00007FFF, 32'h0, 32'h3, 32'h7, 32'hFF};
   localparam word_t rate_tab [8] = '{`RATE_125K, `RATE_250K, `RATE_500K, `RATE_1MEG,
      `RATE_2MEG, `RATE_4MEG, `RATE_8MEG, `RATE_8MEG};
   localparam int half_tab [8] = '{266, 133, 66, 33, 16, 8, 4, 4};

   logic        clk_sys_i     = 1'b0;
   logic        clk_link_i    = 1'b0;
   logic        rst_n_i       = 1'b0;
   logic [11:0] reg_addr_i    = 12'h000;
   word_t       reg_wdata_i   = 32'h0;
   logic        reg_we_i      = 1'b0;
   logic        reg_re_i      = 1'b0;
   logic        start_i       = 1'b0;
   logic        dma_rd_ack_i  = 1'b0;
   byte_t       dma_rd_data_i = 8'h00;
   logic        dma_wr_ack_i  = 1'b0;
   logic [2:0]  fmt           = 3'h0;
   word_t       reg_rdata_o, dma_rd_addr_o, dma_wr_addr_o, tb, rb;
   logic        busy_o, end_o, dma_rd_req_o, dma_wr_req_o, sck_o, mosi_o, miso_i;
   byte_t       dma_wr_data_o;
   int          errors = 0, cmp_count = 0, nrd = 0, nwr = 0, nend = 0;
   byte_t       wr_mem [word_t];
   realtime     t_prev, t_last;

   always #2.5 clk_sys_i = ~clk_sys_i;
   initial #1.3 forever #7.5 clk_link_i = ~clk_link_i;

   spi_master_dma_config i_spi_master_dma_config (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
      .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .start_i(start_i), .busy_o(busy_o),
      .end_o(end_o), .dma_rd_req_o(dma_rd_req_o), .dma_rd_addr_o(dma_rd_addr_o),
      .dma_rd_ack_i(dma_rd_ack_i), .dma_rd_data_i(dma_rd_data_i),
      .dma_wr_req_o(dma_wr_req_o), .dma_wr_addr_o(dma_wr_addr_o),
      .dma_wr_data_o(dma_wr_data_o), .dma_wr_ack_i(dma_wr_ack_i), .sck_o(sck_o),
      .mosi_o(mosi_o), .miso_i(miso_i));

   spi_slave_model i_spi_slave_model (.sck_i(sck_o), .mosi_i(mosi_o), .clock_polarity_i(fmt[2]),
      .clock_phase_i(fmt[1]), .order_i(fmt[0]), .miso_o(miso_i));

   function automatic byte_t tx_mem(input word_t a);
      return a[7:0] ^ {a[3:0], a[11:8]} ^ 8'h5A;
   endfunction

   function automatic byte_t pat(input int f);
      return byte_t'(f * 77) ^ 8'hC3;
   endfunction

   always @(sck_o) begin
      t_prev = t_last;
      t_last = $realtime;
   end

   // memory side of the dma port, stalling at random
   always @(posedge clk_sys_i) begin
      dma_rd_ack_i <= 1'b0;
      dma_wr_ack_i <= 1'b0;
      if (end_o === 1'b1) nend <= nend + 1;
      if (dma_rd_req_o === 1'b1 && !dma_rd_ack_i && $urandom_range(2) == 0) begin
         dma_rd_ack_i  <= 1'b1;
         dma_rd_data_i <= tx_mem(dma_rd_addr_o);
         nrd <= nrd + 1;
      end
      if (dma_wr_req_o === 1'b1 && !dma_wr_ack_i && $urandom_range(3) == 0) begin
         dma_wr_ack_i <= 1'b1;
         wr_mem[dma_wr_addr_o] = dma_wr_data_o;
         nwr <= nwr + 1;
      end
   end

   task automatic stop_test();
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input word_t got, input word_t exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [11:0] a, input word_t d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_we_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_we_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic reg_rd(input logic [11:0] a, output word_t d);
      reg_addr_i <= a;
      reg_re_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_re_i <= 1'b0;
      // read data stand between this edge and the next one only
      #1 d = reg_rdata_o;
      @(posedge clk_sys_i);
   endtask

   task automatic run_xfer(input int k);
      int    txl, rxl, n, t, f0;
      byte_t fil, e;
      word_t rd, g;
      fil = byte_t'($urandom);
      txl = (half_tab[k] > 40) ? $urandom_range(1) : $urandom_range(3);
      txl = (k == 6) ? 1 : (k == 7) ? 3 : txl;
      rxl = (k == 6) ? 3 : (k == 7 || half_tab[k] > 40) ? 1 : 1 + $urandom_range(2);
      fmt = k[2:0];
      reg_wr(`OFS_BIT_RATE_SELECT, rate_tab[k]);
      reg_wr(`OFS_SERIAL_FORMAT_CONFIG, word_t'(k[2:0]));
      reg_wr(`OFS_OVERREAD_FILLER, word_t'(fil));
      reg_wr(`OFS_RX_LIST_TYPE, word_t'(k >= 6));
      reg_wr(`OFS_TX_LIST_TYPE, word_t'(k >= 6));
      reg_wr(`OFS_RX_BYTE_LIMIT, word_t'(rxl));
      reg_wr(`OFS_TX_BYTE_COUNT_LIMIT, word_t'(txl));
      // pointers kept on runs 5 and 7 to see the base hold or advance
      if (k != 5 && k != 7) begin
         tb = $urandom;
         rb = $urandom;
         reg_wr(`OFS_TX_BUFFER_POINTER, tb);
         reg_wr(`OFS_RX_BUFFER_POINTER, rb);
      end
      repeat (40) @(posedge clk_sys_i);
      chk(word_t'(sck_o), word_t'(k[2]));
      f0 = i_spi_slave_model.frame_n;
      i_spi_slave_model.got_q.delete();
      wr_mem.delete();
      nrd = 0;
      nwr = 0;
      nend = 0;
      // start held a second cycle while busy, which must be ignored
      start_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      start_i <= 1'b0;
      chk(word_t'(busy_o), 32'h1);
      for (t = 0; t < 20000 && nend == 0; t++) @(posedge clk_sys_i);
      repeat (8) @(posedge clk_sys_i);
      chk(word_t'(busy_o), 32'h0);
      n = (rxl > txl) ? rxl : txl;
      chk(word_t'(nend), 32'h1);
      chk(word_t'(i_spi_slave_model.got_q.size()), word_t'(n));
      for (int i = 0; i < i_spi_slave_model.got_q.size(); i++) begin
         e = (i < txl) ? tx_mem(tb + i) : fil;
         chk(word_t'(i_spi_slave_model.got_q[i]), word_t'(e));
      end
      chk(word_t'(nrd), word_t'(txl));
      chk(word_t'(nwr), word_t'(rxl));
      for (int i = 0; i < rxl; i++) begin
         g = wr_mem.exists(rb + i) ? word_t'(wr_mem[rb + i]) : 32'hFFFFFFFF;
         chk(g, word_t'(pat(f0 + i)));
      end
      reg_rd(`OFS_RX_BYTE_COUNT, rd);
      chk(rd, word_t'(rxl));
      reg_rd(`OFS_TX_BYTE_COUNT, rd);
      chk(rd, word_t'(txl));
      g = word_t'($rtoi((t_last - t_prev) * 1000.0 + 0.5));
      chk(g, word_t'(half_tab[k] * 15000));
      if (k >= 6) begin
         tb = tb + txl;
         rb = rb + rxl;
      end
   endtask

   initial begin
      #400000;
      errors++;
      stop_test();
   end

   initial begin
      word_t rd;
      word_t v;
      void'($urandom(32'h2b95124d));
      // reset must also span four link clock edges
      repeat (13) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      for (int i = 0; i < 11; i++) begin
         reg_rd(ofs_tab[i], rd);
         chk(rd, (i == 0) ? `RST_BIT_RATE_SELECT : `RST_WORD_ZERO);
      end
      for (int i = 0; i < 11; i++) begin
         v = $urandom;
         if (i == 9) fmt = v[2:0];
         reg_wr(ofs_tab[i], v);
         reg_rd(ofs_tab[i], rd);
         chk(rd, v & msk_tab[i]);
      end
      reg_wr(12'h600, 32'hFFFFFFFF);
      reg_rd(12'h600, rd);
      chk(rd, 32'h0);
      for (int k = 0; k < 8; k++) run_xfer(k);
      reg_wr(`OFS_RX_BYTE_LIMIT, 32'h0);
      reg_wr(`OFS_TX_BYTE_COUNT_LIMIT, 32'h0);
      start_i <= 1'b1;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      @(posedge clk_sys_i);
      // end pulse stands for the one cycle after this edge
      #1 chk(word_t'(end_o), 32'h1);
      @(posedge clk_sys_i);
      reg_rd(`OFS_TX_BYTE_COUNT, rd);
      chk(rd, 32'h0);
      stop_test();
   end
endmodule // spi_master_dma_config_bench

`default_nettype wire
